// [design/ssmts_pkg.sv]
// Shared constants and types of the select mode and transmit status block.
package ssmts_pkg;

  // ==========================================================================
  // Control and status field layout
  // ==========================================================================
  localparam int STAT_W        = 4;  // Width of the status image.
  localparam int BIT_ENABLE    = 0;  // Serial port enable position.
  localparam int BIT_TX_EMPTY  = 1;  // Transmit buffer empty position.
  localparam int BIT_MODE_LO   = 2;  // Low slave-select mode bit.
  localparam int BIT_MODE_HI   = 3;  // High slave-select mode bit.
  localparam int DATA_W        = 8;  // Byte width of the transmit path.

  // ==========================================================================
  // Slave-select mode encodings
  // ==========================================================================
  localparam logic [1:0] MODE_3WIRE    = 2'h0; // Line not routed to a pin.
  localparam logic [1:0] MODE_4W_SLAVE = 2'h1; // Line is always an input.
  localparam logic [1:0] MODE_RESET    = 2'h1; // Default mode after reset.

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic             TX_EMPTY_RST = 1'b1;
  localparam logic [1:0]       SYNC_RST     = 2'h2; // Bit 1 select, bit 0 clk.
  localparam int               SYNC_SEL     = 1;
  localparam int               SYNC_CLK     = 0;
  localparam logic [2:0]       LAST_BIT     = 3'h7; // Final bit of a byte.
  localparam logic [DATA_W-1:0] DATA_RST    = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       enable;
    logic [1:0] mode;
  } ssmts_ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } ssmts_state_e;

endpackage : ssmts_pkg

// [design/ssmts_sync.sv]
// Two-flop synchroniser for the pin-side inputs of the block.
`timescale 1ns/1ps
module ssmts_sync
  import ssmts_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Asynchronous inputs and their synchronised copies
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  logic [1:0] meta_r;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r   <= SYNC_RST;
      sync_out <= SYNC_RST;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // ssmts_sync

// [design/ssmts_top.sv]
// Slave-select mode control, transmit buffer and empty flag of the port.
// Overview of operation
// - Mode 00: three-wire, select line unrouted.
// - Mode 01 default: select line always input.
// - Mode 1x: drive select line with low bit.
// - Writing a byte clears buffer-empty flag.
// - Move to shifter sets buffer-empty flag.
// - Enable bit off makes port inactive.
`timescale 1ns/1ps
module ssmts_top
  import ssmts_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RSTN,
  // Configuration
  input  wire logic              SERIAL_PORT_ENABLE,
  input  wire logic [1:0]        SLAVE_SELECT_MODE,
  // Transmit buffer write port
  input  wire logic              TX_WRITE,
  input  wire logic [DATA_W-1:0] TX_DATA,
  // Link pins
  input  wire logic              SERIAL_CLOCK_IN,
  input  wire logic              SLAVE_SELECT_LINE_IN,
  output logic                   SLAVE_SELECT_LINE_OUT,
  output logic                   SLAVE_SELECT_LINE_OE_N,
  output logic                   SLAVE_SELECT_ROUTED,
  output logic                   SERIAL_DATA_OUT,
  // Status
  output logic                   TX_BUFFER_EMPTY,
  output logic                   SHIFT_BUSY,
  output logic [STAT_W-1:0]      STATUS_IMAGE
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ssmts_ctrl_s       ctrl;
  ssmts_state_e      state_r;
  ssmts_state_e      state_nxt;
  logic [1:0]        sync_w;
  logic              clk_prev_r;
  logic              clk_fall;
  logic              link_active;
  logic              load;
  logic [DATA_W-1:0] buf_r;
  logic [DATA_W-1:0] shift_r;
  logic [2:0]        bit_cnt_r;
  logic              wr_ok;

  // Drives the select line in the single-master modes.
  function automatic logic is_master(input logic [1:0] mode);
    return mode[1];
  endfunction

  assign ctrl.enable = SERIAL_PORT_ENABLE;
  assign ctrl.mode   = SLAVE_SELECT_MODE;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Both the link clock and the select line come from outside this domain.
  ssmts_sync u_sync (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .async_in ({SLAVE_SELECT_LINE_IN, SERIAL_CLOCK_IN}),
    .sync_out (sync_w)
  );

  // Previous link clock level, for edge detection on the synced copy.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= sync_w[SYNC_CLK];
    end
  end

  assign clk_fall = clk_prev_r & ~sync_w[SYNC_CLK];

  // ==========================================================================
  // Activity qualification
  // ==========================================================================
  // mode 01 selection
  // In four-wire slave mode the link only runs while the master selects us.
  // enable gating
  // A disabled port neither accepts bytes nor moves data.
  always_comb begin
    link_active = 1'b0;
    if (ctrl.enable) begin
      if (ctrl.mode == MODE_4W_SLAVE) begin
        link_active = ~sync_w[SYNC_SEL];
      end else begin
        link_active = 1'b1;
      end
    end
  end

  assign wr_ok = TX_WRITE & ctrl.enable;
  assign load  = (state_r == ST_IDLE) & ~TX_BUFFER_EMPTY & link_active;

  // ==========================================================================
  // Slave-select pin control
  // ==========================================================================
  // pin routing
  // The line is released unless enabled in a single-master mode, so a
  // disabled port can never fight another master on the shared wire.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      SLAVE_SELECT_LINE_OUT  <= 1'b1;
      SLAVE_SELECT_LINE_OE_N <= 1'b1;
      SLAVE_SELECT_ROUTED    <= 1'b1;
    end else begin
      SLAVE_SELECT_ROUTED    <= (ctrl.mode != MODE_3WIRE);
      SLAVE_SELECT_LINE_OE_N <= ~(ctrl.enable & is_master(ctrl.mode));
      SLAVE_SELECT_LINE_OUT  <= is_master(ctrl.mode) ? ctrl.mode[0] : 1'b1;
    end
  end

  // ==========================================================================
  // Transmit buffer and empty flag
  // ==========================================================================
  // write clears flag
  // transfer sets flag
  // A write in the cycle of a transfer keeps the new byte pending, so the
  // flag stays low; the older byte still reaches the shifter.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      buf_r           <= DATA_RST;
      TX_BUFFER_EMPTY <= TX_EMPTY_RST;
    end else begin
      if (wr_ok) begin
        buf_r           <= TX_DATA;
        TX_BUFFER_EMPTY <= 1'b0;
      end else if (load) begin
        TX_BUFFER_EMPTY <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Shift sequencing
  // ==========================================================================
  // Next-state decode of the minimal byte shifter.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (load) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!ctrl.enable) begin
          state_nxt = ST_IDLE;
        end else if (clk_fall && link_active && bit_cnt_r == LAST_BIT) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shifter load
  // Data leaves MSB first, one bit per falling link clock edge.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      shift_r         <= DATA_RST;
      bit_cnt_r       <= 3'h0;
      SERIAL_DATA_OUT <= 1'b0;
    end else if (load) begin
      shift_r         <= buf_r;
      bit_cnt_r       <= 3'h0;
      SERIAL_DATA_OUT <= buf_r[DATA_W-1];
    end else if (state_r == ST_SHIFT && clk_fall && link_active) begin
      shift_r         <= {shift_r[DATA_W-2:0], 1'b0};
      bit_cnt_r       <= bit_cnt_r + 3'h1;
      SERIAL_DATA_OUT <= shift_r[DATA_W-2];
    end
  end

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  // Busy and status image are registered so every output is a flop.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      SHIFT_BUSY   <= 1'b0;
      STATUS_IMAGE <= {MODE_RESET, TX_EMPTY_RST, 1'b0};
    end else begin
      SHIFT_BUSY                 <= (state_nxt == ST_SHIFT);
      STATUS_IMAGE[BIT_MODE_HI]  <= ctrl.mode[1];
      STATUS_IMAGE[BIT_MODE_LO]  <= ctrl.mode[0];
      STATUS_IMAGE[BIT_TX_EMPTY] <= TX_BUFFER_EMPTY;
      STATUS_IMAGE[BIT_ENABLE]   <= ctrl.enable;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  AST_MODE00_UNROUTED: assert property (
    (ctrl.mode == MODE_3WIRE) |=>
      (!SLAVE_SELECT_ROUTED && SLAVE_SELECT_LINE_OE_N)
  ) else $error("Three-wire mode left select line routed or driven.");

  AST_MODE01_INPUT: assert property (
    (ctrl.mode == MODE_4W_SLAVE) |=>
      (SLAVE_SELECT_ROUTED && SLAVE_SELECT_LINE_OE_N)
  ) else $error("Four-wire slave mode drove the select line.");

  AST_MODE1X_DRIVE: assert property (
    (ctrl.mode[1] && ctrl.enable) |=>
      (!SLAVE_SELECT_LINE_OE_N && SLAVE_SELECT_LINE_OUT == $past(ctrl.mode[0]))
  ) else $error("Single-master mode select level wrong.");

  AST_WRITE_CLEARS: assert property (
    wr_ok |=> (!TX_BUFFER_EMPTY && buf_r == $past(TX_DATA))
  ) else $error("Buffer write did not clear the empty flag.");

  AST_LOAD_SETS: assert property (
    (load && !wr_ok) |=> (TX_BUFFER_EMPTY && SHIFT_BUSY)
  ) else $error("Transfer to shifter did not set the empty flag.");

  AST_LOAD_MSB: assert property (
    load |=> (SERIAL_DATA_OUT == $past(buf_r[DATA_W-1]))
  ) else $error("Shifter did not present the buffered MSB.");

  AST_DISABLED_IDLE: assert property (
    !ctrl.enable |=> (state_r == ST_IDLE && SLAVE_SELECT_LINE_OE_N
                      && $stable(TX_BUFFER_EMPTY))
  ) else $error("Disabled port stayed active.");

  AST_SLAVE_DESELECT_HOLD: assert property (
    (ctrl.mode == MODE_4W_SLAVE && sync_w[SYNC_SEL] && state_r == ST_SHIFT
     && ctrl.enable) |=> $stable(bit_cnt_r)
  ) else $error("Deselected slave kept shifting.");

  COV_LOAD: cover property (load ##1 SHIFT_BUSY);
  COV_MASTER_DRIVE: cover property (ctrl.enable && ctrl.mode == 2'h3);
  COV_WRITE_BUSY: cover property (SHIFT_BUSY && wr_ok);
  COV_BYTE_DONE: cover property (SHIFT_BUSY ##1 !SHIFT_BUSY);

endmodule // ssmts_top

// [sim/ssmts_link_model.sv]
// Behavioural serial master that clocks bytes out of the port.
`timescale 1ns/1ps
module ssmts_link_model (
  // Link pins driven by the master
  output logic      sclk,
  output logic      sel_n,
  // Serial data from the port
  input  wire logic sdo
);
  // ==========================================================================
  // Frame engine
  // ==========================================================================
  // Clock parks high between frames; select is released to its pull-up.
  initial begin
    sclk  = 1'b1;
    sel_n = 1'b1;
  end

  // Data is sampled just before each falling edge, since the port only
  // moves to the next bit some clocks after that edge.
  task automatic run_frame(input logic use_sel, input logic gap,
                           output logic [7:0] got);
    sel_n = ~use_sel;
    #160;
    for (int i = 7; i >= 0; i--) begin
      // A gap drops select for two clocks that must not shift anything.
      if (gap && i == 3) begin
        sel_n = 1'b1;
        repeat (2) begin
          #80;
          sclk = 1'b0;
          #80;
          sclk = 1'b1;
        end
        sel_n = 1'b0;
        #160;
      end
      got[i] = sdo;
      sclk   = 1'b0;
      #80;
      sclk   = 1'b1;
      #80;
    end
    sel_n = 1'b1;
  endtask
endmodule // ssmts_link_model

// [sim/ssmts_top_tb.sv]
// Self-checking testbench for the select mode and transmit status block.
`timescale 1ns/1ps
module ssmts_top_tb;
  import ssmts_pkg::*;
  logic       clock, rstn, en, wr, ss_wire, ss_out, ss_oe_n, routed;
  logic       sdo, empty, busy, sclk, sel_n;
  logic [1:0] mode;
  logic [7:0] data, got;
  logic [3:0] stat;
  int         n_mismatch, n_compared;

  // ==========================================================================
  // Design, link master and pin resolution
  // ==========================================================================
  ssmts_top dut (.CLOCK(clock), .RSTN(rstn), .SERIAL_PORT_ENABLE(en),
    .SLAVE_SELECT_MODE(mode), .TX_WRITE(wr), .TX_DATA(data),
    .SERIAL_CLOCK_IN(sclk), .SLAVE_SELECT_LINE_IN(ss_wire),
    .SLAVE_SELECT_LINE_OUT(ss_out), .SLAVE_SELECT_LINE_OE_N(ss_oe_n),
    .SLAVE_SELECT_ROUTED(routed), .SERIAL_DATA_OUT(sdo),
    .TX_BUFFER_EMPTY(empty), .SHIFT_BUSY(busy), .STATUS_IMAGE(stat));
  ssmts_link_model link (.sclk(sclk), .sel_n(sel_n), .sdo(sdo));
  // The port wins the select wire only while its enable is low.
  assign ss_wire = ss_oe_n ? sel_n : ss_out;

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  // Expected pins: routed, enable low, select value.
  function automatic logic [7:0] exp_pins(input logic [1:0] m, input logic e);
    return {5'h00, m != MODE_3WIRE, ~(e & m[1]), m[1] ? m[0] : 1'b1};
  endfunction

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %0h got %0h", $time, exp, act);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Kind 0 waits for an idle shifter, kind 1 for a load; bounded either way.
  task automatic wait_until(input int kind);
    for (int n = 0; n < 60; n++) begin
      @(negedge clock);
      if (kind == 0 && busy === 1'b0) return;
      if (kind == 1 && busy === 1'b1 && empty === 1'b1) return;
    end
    n_mismatch++;
    print_verdict();
  endtask

  // One byte through the port in mode m.
  task automatic send(input logic [1:0] m, input logic [7:0] d);
    @(negedge clock);
    mode = m;
    en   = 1'b1;
    // Settle the select pin and its synchroniser before writing.
    repeat (4) @(negedge clock);
    wait_until(0);
    wr   = 1'b1;
    data = d;
    @(negedge clock);
    wr = 1'b0;
    chk(8'(empty), 8'h00);
    if (m == MODE_4W_SLAVE) begin
      repeat (4) @(negedge clock);
      chk({6'h00, busy, empty}, 8'h00);
      chk({4'h0, stat}, {4'h0, m, 2'h1});
    end else begin
      wait_until(1);
    end
    link.run_frame(m == MODE_4W_SLAVE, 1'b0, got);
    chk(got, d);
    wait_until(0);
    chk(8'(empty), 8'h01);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rstn = 1'b0;
    en   = 1'b0;
    mode = MODE_RESET;
    wr   = 1'b0;
    data = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(47684));
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    chk({4'h0, empty, busy, ss_oe_n, routed}, 8'h0B);
    chk({4'h0, stat}, 8'h06);
    $display("test reset done");
    // Every mode with the port both off and on.
    for (int k = 0; k < 8; k++) begin
      {en, mode} = 3'(k);
      repeat (2) @(negedge clock);
      chk({5'h00, routed, ss_oe_n, ss_out}, exp_pins(mode, en));
      chk({4'h0, stat}, {4'h0, mode, 1'b1, en});
    end
    $display("test modes done");
    send(2'h0, 8'h00);
    send(2'h1, 8'hFF);
    send(2'h2, 8'hA5);
    send(2'h3, 8'h5A);
    for (int k = 0; k < 12; k++) begin
      send(2'($urandom), 8'($urandom));
    end
    $display("test transfers done");
    // a second byte may follow once the first reaches the shifter.
    @(negedge clock);
    mode = MODE_3WIRE;
    repeat (4) @(negedge clock);
    wr   = 1'b1;
    data = 8'h96;
    @(negedge clock);
    wr = 1'b0;
    chk(8'(empty), 8'h00);
    wait_until(1);
    wr   = 1'b1;
    data = 8'h69;
    @(negedge clock);
    wr = 1'b0;
    chk({6'h00, busy, empty}, 8'h02);
    link.run_frame(1'b0, 1'b0, got);
    chk(got, 8'h96);
    wait_until(1);
    link.run_frame(1'b0, 1'b0, got);
    chk(got, 8'h69);
    wait_until(0);
    chk(8'(empty), 8'h01);
    $display("test queued byte done");
    // a deselect in mid-byte pauses the shifter.
    @(negedge clock);
    mode = MODE_4W_SLAVE;
    repeat (4) @(negedge clock);
    wr   = 1'b1;
    data = 8'hC6;
    @(negedge clock);
    wr = 1'b0;
    link.run_frame(1'b1, 1'b1, got);
    chk(got, 8'hC6);
    wait_until(0);
    chk(8'(empty), 8'h01);
    $display("test deselect gap done");
    // A write while the port is off leaves the flag set.
    @(negedge clock);
    en   = 1'b0;
    wr   = 1'b1;
    data = 8'h3C;
    @(negedge clock);
    wr = 1'b0;
    repeat (3) @(negedge clock);
    chk({6'h00, empty, busy}, 8'h02);
    $display("test disabled done");
    print_verdict();
  end
endmodule // ssmts_top_tb
